// ---- hdl/ulsr_consts.svh ----
`ifndef ULSR_CONSTS_SVH
`define ULSR_CONSTS_SVH

// ===========================================================================
// register offsets
`define ULSR_OFS_DATA      4'h0
`define ULSR_OFS_CTRL      4'h1
`define ULSR_OFS_LSW       4'h2
`define ULSR_OFS_IRQ_STAT  4'h3
`define ULSR_OFS_IRQ_MASK  4'h4
`define ULSR_OFS_DIVISOR   4'h5

// ===========================================================================
// line status word bit positions
`define ULSR_LSW_RDY       0
`define ULSR_LSW_OVR       1
`define ULSR_LSW_PAR       2
`define ULSR_LSW_FRM       3
`define ULSR_LSW_BRK       4
`define ULSR_LSW_HEMPTY    5
`define ULSR_LSW_TEMPTY    6
`define ULSR_LSW_ERRSUM    7

// ===========================================================================
// control bits
`define ULSR_CTRL_TXIE     0
`define ULSR_CTRL_BUFMODE  1

// ===========================================================================
// interrupt status bits
`define ULSR_IRQ_RXDATA    0
`define ULSR_IRQ_LINEERR   1
`define ULSR_IRQ_TXREADY   2

// ===========================================================================
// reset values
`define ULSR_CTRL_RESET    8'h00
`define ULSR_MASK_RESET    8'h00
`define ULSR_DIV_RESET     8'h01

// ===========================================================================
// sizes and timing counts
`define ULSR_BUF_DEPTH     16
`define ULSR_FRAME_BITS    10

`endif

// ---- hdl/ulsr_pkg.sv ----
package ulsr_pkg;

    // =======================================================================
    // shared types
    typedef logic [7:0] ulsr_byte_t;

    typedef struct packed {
        logic       brk;
        logic       frm;
        logic       par;
        ulsr_byte_t data;
    } ulsr_rx_entry_t;

endpackage : ulsr_pkg

// ---- hdl/ulsr_fifo.sv ----
`timescale 1ns/10ps

module ulsr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  logic             clk,
    input  logic             rst,
    // control
    input  logic             flush,
    input  logic             push,
    input  logic             pop,
    input  logic [WIDTH-1:0] wdata,
    // state
    output logic [WIDTH-1:0] head,
    output logic [CW-1:0]    count
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // =======================================================================
    // storage
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    wr_ptr_nxt;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW-1:0]    rd_ptr_nxt;
    logic [CW-1:0]    count_r;
    logic [CW-1:0]    count_nxt;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        if (p == PW'(DEPTH - 1)) begin
            return '0;
        end
        return p + PW'(1);
    endfunction : bump

    // =======================================================================
    // pointers; caller never pushes when full nor pops when empty
    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt  = count_r;
        if (flush) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            count_nxt  = '0;
        end else begin
            if (push) begin
                wr_ptr_nxt = bump(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_nxt = bump(rd_ptr_r);
            end
            if (push && !pop) begin
                count_nxt = count_r + CW'(1);
            end else if (pop && !push) begin
                count_nxt = count_r - CW'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r  <= count_nxt;
        end
    end

    // memory has no reset: entries are only read once written
    always_ff @(posedge clk) begin
        if (push && !flush) begin
            mem[wr_ptr_r] <= wdata;
        end
    end

    assign head  = mem[rd_ptr_r];
    assign count = count_r;

endmodule : ulsr_fifo

// ---- hdl/ulsr_line_status.sv ----
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
`include "ulsr_consts.svh"

// ===========================================================================
// Overview of operation
// - error summary set as a parity, framing or break entry enters the buffer, cleared when none remain
// - reading the line status word clears the error summary
// - char mode: transmitter empty when holding and shift stages empty
// - transmitter empty clears when holding or shift stage holds a char
// - buffered mode: transmitter empty only when buffer and shifter empty
// - char mode: holding empty sets when character moves to shift stage
// - character mode: holding empty clears in the cycle of the host write
// - buffered mode: holding empty follows transmit buffer empty
// - transmit-ready interrupt while holding empty and its enable set
// - break flag when receive input low for a full frame time
// - one break entry per break condition, however long
// - framing error flag reads zero after reset
// - framing error flag for bad stop bit, head entry in buffered mode
// - parity error flag for bad parity, head entry in buffered mode
// - overrun flag when a character meets a full buffer, buffer untouched
// - data ready flag while received data remains
module ulsr_line_status #(
    parameter int DEPTH      = `ULSR_BUF_DEPTH,
    parameter int FRAME_BITS = `ULSR_FRAME_BITS
) (
    // clock and reset
    input  logic       clk,
    input  logic       rst,
    // register port
    input  logic [3:0] reg_addr,
    input  logic [7:0] reg_wdata,
    input  logic       reg_wr,
    input  logic       reg_rd,
    output logic [7:0] reg_rdata,
    // receiver
    input  logic       rx_char_valid,
    input  logic [7:0] rx_char_data,
    input  logic       rx_char_parity_err,
    input  logic       rx_char_framing_err,
    input  logic       rx_serial_in,
    // transmitter shift stage
    input  logic       tx_shift_busy,
    output logic       tx_shift_load,
    output logic [7:0] tx_shift_data,
    // interrupts
    output logic       tx_ready_irq,
    output logic       irq
);

    localparam int CW  = $clog2(DEPTH + 1);
    localparam int LW  = $clog2(FRAME_BITS + 1);
    localparam int EW  = $bits(ulsr_pkg::ulsr_rx_entry_t);

    // =======================================================================
    // declarations
    logic [7:0]                 ctrl_r;
    logic [7:0]                 ctrl_nxt;
    logic [7:0]                 mask_r;
    logic [7:0]                 mask_nxt;
    logic [7:0]                 stat_r;
    logic [7:0]                 stat_nxt;
    logic [7:0]                 div_r;
    logic [7:0]                 div_nxt;
    logic [7:0]                 rdata_r;
    logic [7:0]                 rdata_nxt;
    logic                       ovr_r;
    logic                       ovr_nxt;
    logic                       errsum_r;
    logic                       errsum_nxt;
    logic [CW-1:0]              errcnt_r;
    logic [CW-1:0]              errcnt_nxt;
    logic                       load_r;
    logic                       load_nxt;
    logic [7:0]                 txd_r;
    logic [7:0]                 txd_nxt;
    logic                       hempty_r;
    logic                       irq_r;
    logic                       irq_nxt;
    logic [7:0]                 tick_cnt_r;
    logic [7:0]                 tick_cnt_nxt;
    logic [LW-1:0]              low_cnt_r;
    logic [LW-1:0]              low_cnt_nxt;
    logic                       brk_armed_r;
    logic                       brk_armed_nxt;

    logic                       buf_mode;
    logic                       flush;
    logic [CW-1:0]              limit;
    logic                       wr_data;
    logic                       rd_data;
    logic                       rd_lsw;
    logic                       tick;
    logic                       brk_evt;
    logic                       rx_new;
    logic                       rx_push;
    logic                       rx_pop;
    logic                       rx_full;
    logic                       ovr_evt;
    logic                       push_err;
    logic                       pop_err;
    logic                       tx_push;
    logic                       tx_pop;
    logic                       tx_full;
    logic                       hempty;
    logic                       tempty;
    logic [7:0]                 lsw;
    logic [CW-1:0]              rx_count;
    logic [CW-1:0]              tx_count;
    logic [7:0]                 tx_head;
    ulsr_pkg::ulsr_rx_entry_t   rx_head;
    ulsr_pkg::ulsr_rx_entry_t   rx_went;

    // =======================================================================
    // decode
    always_comb begin
        buf_mode = ctrl_r[`ULSR_CTRL_BUFMODE];
        wr_data  = reg_wr && (reg_addr == `ULSR_OFS_DATA);
        rd_data  = reg_rd && (reg_addr == `ULSR_OFS_DATA);
        rd_lsw   = reg_rd && (reg_addr == `ULSR_OFS_LSW);
        // switching mode empties the receive and transmit buffers, as the layout changes
        flush    = reg_wr && (reg_addr == `ULSR_OFS_CTRL)
                   && (reg_wdata[`ULSR_CTRL_BUFMODE] != buf_mode);
        limit    = buf_mode ? CW'(DEPTH) : CW'(1);
    end

    // =======================================================================
    // break detection
    always_comb begin
        tick          = (tick_cnt_r == 8'h00);
        tick_cnt_nxt  = tick_cnt_r - 8'h01;
        if (tick) begin
            tick_cnt_nxt = (div_r == 8'h00) ? 8'h00 : div_r - 8'h01;
        end
        low_cnt_nxt   = low_cnt_r;
        brk_armed_nxt = brk_armed_r;
        brk_evt       = brk_armed_r && (low_cnt_r == LW'(FRAME_BITS));
        if (rx_serial_in) begin
            low_cnt_nxt   = '0;
            brk_armed_nxt = 1'b1;
        end else begin
            if (tick && (low_cnt_r < LW'(FRAME_BITS))) begin
                low_cnt_nxt = low_cnt_r + LW'(1);
            end
            if (brk_evt) begin
                brk_armed_nxt = 1'b0;
            end
        end
    end

    // =======================================================================
    // receive side
    always_comb begin
        rx_went.brk  = brk_evt;
        rx_went.frm  = brk_evt ? 1'b0 : rx_char_framing_err;
        rx_went.par  = brk_evt ? 1'b0 : rx_char_parity_err;
        rx_went.data = brk_evt ? 8'h00 : rx_char_data;
        rx_new       = rx_char_valid || brk_evt;
        rx_pop       = rd_data && (rx_count != '0) && !flush;
        rx_full      = (rx_count >= limit) && !rx_pop;
        // full buffer refuses the new character
        ovr_evt      = rx_new && rx_full && !flush;
        rx_push      = rx_new && !rx_full && !flush;
        push_err     = rx_push && (rx_went.brk || rx_went.frm || rx_went.par);
        pop_err      = rx_pop && (rx_head.brk || rx_head.frm || rx_head.par);
        errcnt_nxt   = errcnt_r;
        if (flush) begin
            errcnt_nxt = '0;
        end else if (push_err && !pop_err) begin
            errcnt_nxt = errcnt_r + CW'(1);
        end else if (pop_err && !push_err) begin
            errcnt_nxt = errcnt_r - CW'(1);
        end
        // status read clears, new error wins
        errsum_nxt = (errsum_r && !rd_lsw) || push_err;
        if (errcnt_nxt == '0) begin
            errsum_nxt = 1'b0;
        end
        ovr_nxt = (ovr_r && !rd_lsw) || ovr_evt;
    end

    ulsr_fifo #(
        .WIDTH (EW),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_rx_buf (
        .clk   (clk),
        .rst   (rst),
        .flush (flush),
        .push  (rx_push),
        .pop   (rx_pop),
        .wdata (rx_went),
        .head  (rx_head),
        .count (rx_count)
    );

    // =======================================================================
    // transmit side
    always_comb begin
        tx_pop   = (tx_count != '0) && !tx_shift_busy && !load_r && !flush;
        tx_full  = (tx_count >= limit) && !tx_pop;
        tx_push  = wr_data && !tx_full && !flush;
        load_nxt = tx_pop;
        txd_nxt  = tx_pop ? tx_head : txd_r;
        // set once the stage drains to the shifter
        hempty   = (tx_count == '0) && !tx_push;
        tempty   = hempty && !tx_shift_busy && !load_r;
    end

    ulsr_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_tx_buf (
        .clk   (clk),
        .rst   (rst),
        .flush (flush),
        .push  (tx_push),
        .pop   (tx_pop),
        .wdata (reg_wdata),
        .head  (tx_head),
        .count (tx_count)
    );

    // =======================================================================
    // status word and registers
    always_comb begin
        lsw = 8'h00;
        lsw[`ULSR_LSW_RDY]    = (rx_count != '0);
        lsw[`ULSR_LSW_OVR]    = ovr_r;
        lsw[`ULSR_LSW_PAR]    = (rx_count != '0) && rx_head.par;
        lsw[`ULSR_LSW_FRM]    = (rx_count != '0) && rx_head.frm;
        lsw[`ULSR_LSW_BRK]    = (rx_count != '0) && rx_head.brk;
        lsw[`ULSR_LSW_HEMPTY] = hempty;
        lsw[`ULSR_LSW_TEMPTY] = tempty;
        lsw[`ULSR_LSW_ERRSUM] = errsum_r;

        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        div_nxt  = div_r;
        stat_nxt = stat_r;
        // the status word offset takes no write
        if (reg_wr) begin
            unique case (reg_addr)
                `ULSR_OFS_CTRL:     ctrl_nxt = reg_wdata & 8'h03;
                `ULSR_OFS_IRQ_MASK: mask_nxt = reg_wdata & 8'h07;
                `ULSR_OFS_DIVISOR:  div_nxt  = reg_wdata;
                `ULSR_OFS_IRQ_STAT: stat_nxt = stat_r & ~reg_wdata;
                default:            ;
            endcase
        end
        // events after the clear, so a same-cycle event survives
        stat_nxt[`ULSR_IRQ_RXDATA]  = stat_nxt[`ULSR_IRQ_RXDATA] || rx_push;
        stat_nxt[`ULSR_IRQ_LINEERR] = stat_nxt[`ULSR_IRQ_LINEERR]
                                      || push_err || ovr_evt;
        stat_nxt[`ULSR_IRQ_TXREADY] = stat_nxt[`ULSR_IRQ_TXREADY]
                                      || (hempty && !hempty_r);
        irq_nxt = |(stat_nxt & mask_nxt);

        rdata_nxt = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `ULSR_OFS_DATA:     rdata_nxt = rx_head.data
                                                & {8{rx_count != '0}};
                `ULSR_OFS_CTRL:     rdata_nxt = ctrl_r;
                `ULSR_OFS_LSW:      rdata_nxt = lsw;
                `ULSR_OFS_IRQ_STAT: rdata_nxt = stat_r;
                `ULSR_OFS_IRQ_MASK: rdata_nxt = mask_r;
                `ULSR_OFS_DIVISOR:  rdata_nxt = div_r;
                default:            rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r      <= `ULSR_CTRL_RESET;
            mask_r      <= `ULSR_MASK_RESET;
            div_r       <= `ULSR_DIV_RESET;
            stat_r      <= 8'h00;
            rdata_r     <= 8'h00;
            ovr_r       <= 1'b0;
            errsum_r    <= 1'b0;
            errcnt_r    <= '0;
            load_r      <= 1'b0;
            txd_r       <= 8'h00;
            hempty_r    <= 1'b1;
            irq_r       <= 1'b0;
            tick_cnt_r  <= 8'h00;
            low_cnt_r   <= '0;
            brk_armed_r <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            mask_r      <= mask_nxt;
            div_r       <= div_nxt;
            stat_r      <= stat_nxt;
            rdata_r     <= rdata_nxt;
            ovr_r       <= ovr_nxt;
            errsum_r    <= errsum_nxt;
            errcnt_r    <= errcnt_nxt;
            load_r      <= load_nxt;
            txd_r       <= txd_nxt;
            hempty_r    <= hempty;
            irq_r       <= irq_nxt;
            tick_cnt_r  <= tick_cnt_nxt;
            low_cnt_r   <= low_cnt_nxt;
            brk_armed_r <= brk_armed_nxt;
        end
    end

    // =======================================================================
    // outputs
    assign reg_rdata     = rdata_r;
    assign tx_shift_load = load_r;
    assign tx_shift_data = txd_r;
    assign irq           = irq_r;
    assign tx_ready_irq  = hempty && ctrl_r[`ULSR_CTRL_TXIE];

endmodule : ulsr_line_status

// ---- test/ulsr_line_status_props.sv ----
`timescale 1ns/10ps
`include "ulsr_consts.svh"

// ===========================================================================
// checker on the top ports only
module ulsr_line_status_props (
    // clock and reset
    input logic       clk,
    input logic       rst,
    // register port
    input logic [3:0] reg_addr,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_rdata,
    // receiver
    input logic       rx_char_valid,
    input logic       rx_char_parity_err,
    input logic       rx_char_framing_err,
    input logic       rx_serial_in,
    // transmitter
    input logic       tx_shift_busy,
    input logic       tx_shift_load,
    input logic [7:0] tx_shift_data,
    input logic       tx_ready_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ======================================================================
    // helpers: quiet means no event can touch the flags
    wire lsw_rd = reg_rd && reg_addr == `ULSR_OFS_LSW;
    wire dat_wr = reg_wr && reg_addr == `ULSR_OFS_DATA;
    wire quiet  = !rx_char_valid && rx_serial_in;
    wire idle   = !reg_wr && !reg_rd;

    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    rx_ready_a: assert property (
        rx_char_valid && idle ##1 idle ##1 lsw_rd |=> reg_rdata[0])
        else $error("data ready missing after a character");
    err_sum_a: assert property (
        rx_char_valid && (rx_char_parity_err || rx_char_framing_err) && idle
        ##1 idle ##1 lsw_rd |=> reg_rdata[7] || reg_rdata[1])
        else $error("error summary missing after a bad character");
    read_clear_a: assert property (
        lsw_rd && quiet ##1 quiet && idle ##1 lsw_rd && quiet
        |=> !reg_rdata[7] && !reg_rdata[1])
        else $error("status read did not clear summary or overrun");
    tx_busy_a: assert property (
        lsw_rd && (tx_shift_busy || tx_shift_load) |=> !reg_rdata[6])
        else $error("transmitter empty while shift stage busy");
    wr_hold_a: assert property (
        dat_wr |-> !tx_ready_irq ##1 !tx_ready_irq)
        else $error("ready request during or after a data write");
    buf_full_a: assert property (
        dat_wr && tx_shift_busy ##1 tx_shift_busy && !reg_wr
        ##1 lsw_rd && tx_shift_busy |=> !reg_rdata[5] && !reg_rdata[6])
        else $error("holding empty while a byte waits");
    load_free_a: assert property (
        tx_shift_load |-> !$past(tx_shift_busy))
        else $error("shift stage loaded while busy");
    load_gap_a: assert property (
        tx_shift_load |=> !tx_shift_load)
        else $error("shift loads back to back");
    data_hold_a: assert property (
        !tx_shift_load |-> $stable(tx_shift_data))
        else $error("shift data moved without a load");
endmodule : ulsr_line_status_props

bind ulsr_line_status ulsr_line_status_props props_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_char_valid(rx_char_valid),
    .rx_char_parity_err(rx_char_parity_err),
    .rx_char_framing_err(rx_char_framing_err),
    .rx_serial_in(rx_serial_in), .tx_shift_busy(tx_shift_busy),
    .tx_shift_load(tx_shift_load), .tx_shift_data(tx_shift_data),
    .tx_ready_irq(tx_ready_irq));

// ---- test/ulsr_shift_model.sv ----
`timescale 1ns/10ps

// ===========================================================================
// transmit shift stage: busy for hold_cycles + 1 cycles after each load
module ulsr_shift_model (
    // clock and reset
    input  logic       clk,
    input  logic       rst,
    // shift stage side
    input  logic       tx_shift_load,
    input  logic [7:0] tx_shift_data,
    output logic       tx_shift_busy,
    // bench side
    input  logic [7:0] hold_cycles,
    output logic [7:0] last_byte,
    output int         n_loads
);
    logic [7:0] left_r;

    // busy rises the edge after a load, else a second load may follow
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_shift_busy <= 1'b0;
            last_byte     <= 8'h00;
            n_loads       <= 0;
            left_r        <= 8'h00;
        end else if (tx_shift_load) begin
            tx_shift_busy <= 1'b1;
            last_byte     <= tx_shift_data;
            n_loads       <= n_loads + 1;
            left_r        <= hold_cycles;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end else begin
            tx_shift_busy <= 1'b0;
        end
    end
endmodule : ulsr_shift_model

// ---- test/tb_ulsr_line_status.sv ----
`timescale 1ns/10ps
`include "ulsr_consts.svh"

module tb_ulsr_line_status;
    // =======================================================================
    // signals
    logic       clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, rx_char_data = 8'h00, hold = 8'h1e;
    logic       rx_char_valid = 1'b0, pe = 1'b0, fe = 1'b0;
    logic       rx_serial_in = 1'b1, busy, load, tx_ready_irq, irq;
    logic [7:0] reg_rdata, shift_data, last_byte;
    int         n_loads, n_mismatch = 0, comparisons = 0, cyc = 0, i;

    always #5 clk = ~clk;

    ulsr_line_status dut_u (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
        .rx_char_parity_err(pe), .rx_char_framing_err(fe),
        .rx_serial_in(rx_serial_in), .tx_shift_busy(busy),
        .tx_shift_load(load), .tx_shift_data(shift_data),
        .tx_ready_irq(tx_ready_irq), .irq(irq));

    ulsr_shift_model shift_u (
        .clk(clk), .rst(rst), .tx_shift_load(load),
        .tx_shift_data(shift_data), .tx_shift_busy(busy),
        .hold_cycles(hold), .last_byte(last_byte), .n_loads(n_loads));

    // =======================================================================
    // tasks
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [7:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [3:0] a, input logic [7:0] e, string nm);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(nm, reg_rdata, e);
    endtask : rdc

    task automatic rxc(input logic [7:0] d, input logic p, f);
        @(posedge clk);
        rx_char_valid <= 1'b1;
        rx_char_data  <= d;
        pe            <= p;
        fe            <= f;
        @(posedge clk);
        rx_char_valid <= 1'b0;
    endtask : rxc

    task automatic wait_tx(input int k);
        for (int n = 0; n < 300 && (n_loads < k || busy); n++) @(posedge clk);
    endtask : wait_tx

    // timeout well above the expected run of a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // =======================================================================
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc(`ULSR_OFS_LSW, 8'h60, "lsw reset");
        rdc(`ULSR_OFS_CTRL, 8'h00, "ctrl reset");
        rdc(`ULSR_OFS_DIVISOR, 8'h01, "divisor reset");
        rdc(4'h9, 8'h00, "unmapped");
        wr(`ULSR_OFS_LSW, 8'hff);
        rdc(`ULSR_OFS_LSW, 8'h60, "lsw after write");
        // character mode receive
        rxc(8'h5a, 1'b1, 1'b0);
        rdc(`ULSR_OFS_LSW, 8'he5, "lsw parity");
        rdc(`ULSR_OFS_LSW, 8'h65, "lsw reread");
        rdc(`ULSR_OFS_DATA, 8'h5a, "rx data");
        rdc(`ULSR_OFS_LSW, 8'h60, "lsw drained");
        rxc(8'h33, 1'b0, 1'b1);
        rxc(8'h44, 1'b0, 1'b0);
        rdc(`ULSR_OFS_LSW, 8'heb, "lsw framing overrun");
        rdc(`ULSR_OFS_LSW, 8'h69, "lsw overrun cleared");
        rdc(`ULSR_OFS_DATA, 8'h33, "rx kept");
        chk("irq masked", {7'h00, irq}, 8'h00);
        // character mode transmit with ready request
        wr(`ULSR_OFS_IRQ_MASK, 8'h04);
        wr(`ULSR_OFS_CTRL, 8'h01);
        #1 chk("ready req", {7'h00, tx_ready_irq}, 8'h01);
        wr(`ULSR_OFS_DATA, 8'ha5);
        #1 chk("ready req drop", {7'h00, tx_ready_irq}, 8'h00);
        // wait for the load only: the shifter must still be busy here
        while (n_loads < 1) @(posedge clk);
        rdc(`ULSR_OFS_LSW, 8'h20, "lsw shifting");
        chk("tx byte", last_byte, 8'ha5);
        chk("irq raised", {7'h00, irq}, 8'h01);
        rdc(`ULSR_OFS_IRQ_STAT, 8'h07, "irq status");
        wr(`ULSR_OFS_IRQ_STAT, 8'h07);
        rdc(`ULSR_OFS_IRQ_STAT, 8'h00, "irq cleared");
        chk("irq low", {7'h00, irq}, 8'h00);
        wait_tx(1);
        rdc(`ULSR_OFS_LSW, 8'h60, "lsw tx idle");
        // buffered mode transmit, far side slow
        wr(`ULSR_OFS_CTRL, 8'h02);
        #1 chk("ready off", {7'h00, tx_ready_irq}, 8'h00);
        for (i = 1; i <= 3; i++) wr(`ULSR_OFS_DATA, 8'(i * 17));
        rdc(`ULSR_OFS_LSW, 8'h00, "lsw buffer held");
        for (i = 1; i <= 3; i++) begin
            wait_tx(i + 1);
            chk("tx order", last_byte, 8'(i * 17));
        end
        rdc(`ULSR_OFS_LSW, 8'h60, "lsw buffer idle");
        // buffered receive to full, then one more
        for (i = 0; i < `ULSR_BUF_DEPTH; i++) rxc(8'(i), i == 3, 1'b0);
        rxc(8'hee, 1'b0, 1'b0);
        rdc(`ULSR_OFS_LSW, 8'he3, "lsw full overrun");
        for (i = 0; i < `ULSR_BUF_DEPTH; i++) begin
            if (i == 3) rdc(`ULSR_OFS_LSW, 8'h65, "head parity");
            rdc(`ULSR_OFS_DATA, 8'(i), "rx buffer");
        end
        rdc(`ULSR_OFS_LSW, 8'h60, "lsw buffer empty");
        // long break gives a single break entry
        wr(`ULSR_OFS_DIVISOR, 8'h00);
        @(posedge clk);
        rx_serial_in <= 1'b0;
        repeat (40) @(posedge clk);
        rx_serial_in <= 1'b1;
        rdc(`ULSR_OFS_LSW, 8'hf1, "lsw break");
        rdc(`ULSR_OFS_DATA, 8'h00, "break data");
        rdc(`ULSR_OFS_LSW, 8'h60, "lsw one break");
        end_sim();
    end
endmodule : tb_ulsr_line_status
